/* File: core/pif_top.sv */
// interrupt request and enable flags with shared vector, behind an Avalon-MM slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pif_cfg.svh"

module pif_top (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic [11:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic [1:0] I_CMP_OUT,
	input wire logic I_SERIAL_DONE,
	input wire logic I_UART_RX_DONE,
	input wire logic I_UART_TX_DONE,
	input wire logic I_PIN_A,
	input wire logic I_PIN_B,
	input wire logic I_VECTOR_ACK,
	output logic O_IRQ_REQ,
	output logic [7:0] O_VECTOR_ADDR,
	output logic [1:0] O_CMP_ENABLE,
	output logic [1:0] O_CMP_PIN_OUT_EN,
	output logic [1:0] O_CMP_REF_SEL,
	output logic [1:0] O_CMP_SOURCE_SEL
);

	// ----------------------------------------
	// bus slave decode
	// ----------------------------------------
	logic wait_q;
	logic [31:0] rdata_q;
	wire logic [9:0] idx = I_AVS_ADDRESS[11:2];
	wire logic req = I_AVS_READ | I_AVS_WRITE;
	// a request completes at the edge where waitrequest is sampled low
	wire logic done = req & ~wait_q;
	wire logic wr_lane = done & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
	wire logic [7:0] wbyte = I_AVS_WRITEDATA[7:0];
	wire logic wr_cmp0 = wr_lane & (idx == `PIF_IDX_CMP0);
	wire logic wr_cmp1 = wr_lane & (idx == `PIF_IDX_CMP1);
	wire logic wr_flags = wr_lane & (idx == `PIF_IDX_FLAGS);
	wire logic wr_ien = wr_lane & (idx == `PIF_IDX_IEN);
	wire logic wr_edge = wr_lane & (idx == `PIF_IDX_EDGE);
	wire logic [1:0] wr_cmp = {wr_cmp1, wr_cmp0};

	// ----------------------------------------
	// state
	// ----------------------------------------
	pif_pkg::pif_cmp_ctl_type cmp_q [2];
	logic [1:0] level_q;
	pif_pkg::pif_src_type flag_q;
	pif_pkg::pif_src_type flag_d;
	pif_pkg::pif_src_type ien_q;
	pif_pkg::pif_src_type event_w;
	logic gie_q;
	logic [1:0] edge_q;
	logic pin_a_q;
	logic pin_b_q;
	logic [1:0] cmp_rise;
	logic [1:0] cmp_pend;

	// ----------------------------------------
	// comparators
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			// level is sampled into both level_q and output_level on the same edge, so reads and edge detection see one value
			assign cmp_rise[gi] = I_CMP_OUT[gi] & ~level_q[gi];
			wire logic set_w = cmp_rise[gi] & cmp_q[gi].enable;
			assign cmp_pend[gi] = cmp_q[gi].irq_flag & cmp_q[gi].irq_enable;
			wire logic flag_nx = set_w | (wr_cmp[gi] ? wbyte[`PIF_CMP_FLAG]
				: cmp_q[gi].irq_flag);

			always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
				if (!I_ARST_N) begin
					cmp_q[gi] <= `PIF_CMP_RST;
					level_q[gi] <= 1'b0;
				end else begin
					level_q[gi] <= I_CMP_OUT[gi];
					cmp_q[gi].irq_flag <= flag_nx;
					cmp_q[gi].output_level <= I_CMP_OUT[gi];
					if (wr_cmp[gi]) begin
						cmp_q[gi].enable <= wbyte[`PIF_CMP_EN];
						cmp_q[gi].irq_enable <= wbyte[`PIF_CMP_IEN];
						cmp_q[gi].pin_out_enable <= wbyte[`PIF_CMP_PIN_OE];
						cmp_q[gi].ref_select <= wbyte[`PIF_CMP_REF];
						// only comparator 0 implements the source select
						if (gi == 0) begin
							cmp_q[gi].source_sel <= wbyte[`PIF_CMP_SRC_HI:`PIF_CMP_SRC_LO];
						end
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// loose sources
	// ----------------------------------------
	wire logic pin_a_rise = I_PIN_A & ~pin_a_q;
	wire logic pin_a_fall = ~I_PIN_A & pin_a_q;
	// code 00 is reserved and catches no edge
	wire logic pin_a_ev = (edge_q == `PIF_EDGE_RISE) ? pin_a_rise
		: (edge_q == `PIF_EDGE_FALL) ? pin_a_fall
		: (edge_q == `PIF_EDGE_BOTH) ? (pin_a_rise | pin_a_fall)
		: 1'b0;

	always_comb begin
		event_w.serial_done = I_SERIAL_DONE;
		event_w.uart_rx = I_UART_RX_DONE;
		event_w.uart_tx = I_UART_TX_DONE;
		event_w.pin_int_a = pin_a_ev;
		event_w.pin_int_b = ~I_PIN_B & pin_b_q;
	end

	// events win over a clear in the same cycle
	assign flag_d = event_w | (wr_flags ? wbyte[4:0] : flag_q);

	// ----------------------------------------
	// vector request
	// ----------------------------------------
	wire logic src_pend = |(flag_q & ien_q);
	wire logic any_pend = src_pend | (|cmp_pend);
	// taking the vector drops global enable, as entry to the service routine does
	wire logic gie_d = wr_ien ? wbyte[`PIF_GIE_BIT] : (gie_q & ~I_VECTOR_ACK);
	wire logic irq_d = gie_q & any_pend & ~I_VECTOR_ACK;

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			flag_q <= `PIF_SRC_RST;
			ien_q <= `PIF_SRC_RST;
			gie_q <= 1'b0;
			edge_q <= 2'h0;
			pin_a_q <= 1'b0;
			pin_b_q <= 1'b0;
			O_IRQ_REQ <= 1'b0;
			O_VECTOR_ADDR <= 8'h00;
		end else begin
			flag_q <= flag_d;
			gie_q <= gie_d;
			pin_a_q <= I_PIN_A;
			pin_b_q <= I_PIN_B;
			O_IRQ_REQ <= irq_d;
			O_VECTOR_ADDR <= `PIF_VECTOR_ADDR;
			if (wr_ien) begin
				ien_q <= wbyte[4:0];
			end
			if (wr_edge) begin
				edge_q <= wbyte[`PIF_EDGE_HI:`PIF_EDGE_LO];
			end
		end
	end

	// ----------------------------------------
	// bus answer: one wait cycle, then data
	// ----------------------------------------
	logic [7:0] rbyte;

	always_comb begin
		unique case (idx)
			`PIF_IDX_CMP0: rbyte = cmp_q[0];
			`PIF_IDX_CMP1: rbyte = {cmp_q[1][7:2], 2'h0};
			`PIF_IDX_FLAGS: rbyte = {3'h0, flag_q};
			`PIF_IDX_IEN: rbyte = {gie_q, 2'h0, ien_q};
			`PIF_IDX_EDGE: rbyte = {3'h0, edge_q, 3'h0};
			default: rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(req & wait_q);
			rdata_q <= (req & wait_q & I_AVS_READ) ? {24'h00_0000, rbyte} : 32'h0000_0000;
		end
	end

	assign O_AVS_WAITREQUEST = wait_q;
	assign O_AVS_READDATA = rdata_q;

	// ----------------------------------------
	// pins of the comparator front end
	// ----------------------------------------
	logic [1:0] cen_q;
	logic [1:0] coe_q;
	logic [1:0] cref_q;
	logic [1:0] csrc_q;

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cen_q <= 2'h0;
			coe_q <= 2'h0;
			cref_q <= 2'h0;
			csrc_q <= 2'h0;
		end else begin
			cen_q <= {cmp_q[1].enable, cmp_q[0].enable};
			coe_q <= {cmp_q[1].pin_out_enable, cmp_q[0].pin_out_enable};
			cref_q <= {cmp_q[1].ref_select, cmp_q[0].ref_select};
			csrc_q <= cmp_q[0].source_sel;
		end
	end

	assign O_CMP_ENABLE = cen_q;
	assign O_CMP_PIN_OUT_EN = coe_q;
	assign O_CMP_REF_SEL = cref_q;
	assign O_CMP_SOURCE_SEL = csrc_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);

	sequence s_req_seen;
		req & wait_q;
	endsequence

	sequence s_ack_then_idle;
		!O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endsequence

	a_bus_one_wait: assert property (s_req_seen |=> s_ack_then_idle)
		else $error("bus answer not after exactly one wait cycle");

	a_idle_waits: assert property (!req |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low without a request");

	a_rdata_idle: assert property (
		O_AVS_WAITREQUEST |-> O_AVS_READDATA == 32'h0000_0000)
		else $error("read data driven outside the answer cycle");

	a_cmp0_rise_sets: assert property (
		cmp_rise[0] && cmp_q[0].enable |=> cmp_q[0].irq_flag)
		else $error("comparator 0 rise with enable did not set flag");

	a_cmp1_rise_sets: assert property (
		cmp_rise[1] && cmp_q[1].enable |=> cmp_q[1].irq_flag)
		else $error("comparator 1 rise with enable did not set flag");

	a_cmp1_fall_quiet: assert property (
		!cmp_rise[1] && !wr_cmp1 && !cmp_q[1].irq_flag |=> !cmp_q[1].irq_flag)
		else $error("comparator 1 flag set without a rising edge");

	a_cmp_off_hold: assert property (
		!cmp_q[0].enable && !wr_cmp0 && !cmp_q[0].irq_flag |=> !cmp_q[0].irq_flag)
		else $error("disabled comparator 0 set its flag");

	a_level_follows: assert property (
		1'b1 |=> cmp_q[0].output_level == $past(I_CMP_OUT[0])
			&& cmp_q[1].output_level == $past(I_CMP_OUT[1]))
		else $error("comparator level bit does not follow its input");

	a_cmp1_no_src: assert property (cmp_q[1].source_sel == 2'h0)
		else $error("comparator 1 holds unimplemented bits");

	a_serial_sets: assert property (I_SERIAL_DONE |=> flag_q.serial_done)
		else $error("serial done did not set its flag");

	a_uart_rx_sets: assert property (
		I_UART_RX_DONE |=> flag_q.uart_rx)
		else $error("uart receive done did not set its flag");

	a_uart_tx_sets: assert property (
		I_UART_TX_DONE |=> flag_q.uart_tx)
		else $error("uart transmit done did not set its flag");

	a_pin_b_fall: assert property (
		$fell(I_PIN_B) |=> flag_q.pin_int_b)
		else $error("pin b falling edge lost");

	a_pin_b_steady: assert property (
		!I_PIN_B ##1 (I_PIN_B && !flag_q.pin_int_b && !wr_flags) |=> !flag_q.pin_int_b)
		else $error("pin b flag set on a rising edge");

	a_pin_a_rise: assert property (
		edge_q == `PIF_EDGE_RISE && !I_PIN_A && !flag_q.pin_int_a && !wr_flags
		##1 (!I_PIN_A && !wr_flags) |=> !flag_q.pin_int_a)
		else $error("pin a flag set without selected edge");

	sequence s_pin_a_up;
		!I_PIN_A ##1 (I_PIN_A && edge_q == `PIF_EDGE_RISE);
	endsequence

	a_pin_a_sets: assert property (s_pin_a_up |=> flag_q.pin_int_a)
		else $error("pin a rising edge lost");

	a_set_wins: assert property (
		wr_flags && !wbyte[0] && I_SERIAL_DONE |=> flag_q.serial_done)
		else $error("software clear swallowed a serial event");

	a_irq_needs_gie: assert property (
		!gie_q |=> !O_IRQ_REQ)
		else $error("vector request raised with global enable off");

	a_irq_cmp_on: assert property (
		gie_q && cmp_q[0].irq_flag && cmp_q[0].irq_enable && !I_VECTOR_ACK |=> O_IRQ_REQ)
		else $error("enabled comparator request not raised");

	a_irq_src_on: assert property (
		gie_q && flag_q.serial_done && ien_q.serial_done && !I_VECTOR_ACK |=> O_IRQ_REQ)
		else $error("enabled serial request not raised");

	a_irq_no_ien: assert property (
		ien_q == 5'h00 && !cmp_q[0].irq_enable && !cmp_q[1].irq_enable |=> !O_IRQ_REQ)
		else $error("vector request raised with every source disabled");

	a_ack_drops_gie: assert property (
		I_VECTOR_ACK && !wr_ien |=> !gie_q)
		else $error("global enable survived a vector fetch");

	a_vector_at_8: assert property (
		O_IRQ_REQ |-> O_VECTOR_ADDR == `PIF_VECTOR_ADDR)
		else $error("vector request with wrong vector address");

endmodule : pif_top

`default_nettype wire

/* File: core/pif_cfg.svh */
// register map, field positions, reset values and encodings of the interrupt flag block
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PIF_IDX_CMP0 10'h09C
`define PIF_IDX_CMP1 10'h09D
`define PIF_IDX_FLAGS 10'h0A0
`define PIF_IDX_IEN 10'h0A1
`define PIF_IDX_EDGE 10'h0BF

// ----------------------------------------
// comparator control fields
// ----------------------------------------
`define PIF_CMP_EN 7
`define PIF_CMP_IEN 6
`define PIF_CMP_FLAG 5
`define PIF_CMP_PIN_OE 4
`define PIF_CMP_REF 3
`define PIF_CMP_LEVEL 2
`define PIF_CMP_SRC_HI 1
`define PIF_CMP_SRC_LO 0
`define PIF_CMP_RST 8'h00

// ----------------------------------------
// other fields and values
// ----------------------------------------
`define PIF_GIE_BIT 7
`define PIF_EDGE_HI 4
`define PIF_EDGE_LO 3
`define PIF_EDGE_RISE 2'h1
`define PIF_EDGE_FALL 2'h2
`define PIF_EDGE_BOTH 2'h3
`define PIF_SRC_RST 5'h00
`define PIF_VECTOR_ADDR 8'h08

`endif

/* File: core/pif_pkg.sv */
// types shared by the interrupt flag block
package pif_pkg;

	// ----------------------------------------
	// one bit per loose source; serial sits in bit 0
	// ----------------------------------------
	typedef struct packed {
		logic pin_int_b;
		logic pin_int_a;
		logic uart_tx;
		logic uart_rx;
		logic serial_done;
	} pif_src_type;

	// ----------------------------------------
	// comparator control register layout
	// ----------------------------------------
	typedef struct packed {
		logic enable;
		logic irq_enable;
		logic irq_flag;
		logic pin_out_enable;
		logic ref_select;
		logic output_level;
		logic [1:0] source_sel;
	} pif_cmp_ctl_type;

endpackage : pif_pkg

/* File: tb/pif_core_model.sv */
// model of the processor core that fetches the shared interrupt vector
`timescale 1ns/1ps
`default_nettype none

module pif_core_model (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_irq_req,
	input wire logic [7:0] i_vector_addr,
	input wire logic i_slow,
	output logic o_vector_ack,
	output logic [7:0] o_entries,
	output logic [7:0] o_last_vector
);
	// ----------------------------------------
	// vector fetch
	// ----------------------------------------
	logic [2:0] wait_q;

	// a slow core lets the request stand a few cycles, as a busy instruction would
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_vector_ack <= 1'b0;
			wait_q <= 3'h0;
			o_entries <= 8'h00;
			o_last_vector <= 8'h00;
		end else begin
			o_vector_ack <= 1'b0;
			if (i_irq_req && !o_vector_ack) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q >= (i_slow ? 3'h3 : 3'h0)) begin
					o_vector_ack <= 1'b1;
					wait_q <= 3'h0;
					o_entries <= o_entries + 8'h01;
					o_last_vector <= i_vector_addr;
				end
			end
		end
	end
endmodule : pif_core_model

`default_nettype wire

/* File: tb/pif_top_tb.sv */
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "pif_cfg.svh"

module pif_top_tb;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam logic [11:0] A0 = {`PIF_IDX_CMP0, 2'h0};
	localparam logic [11:0] A1 = {`PIF_IDX_CMP1, 2'h0};
	localparam logic [11:0] AF = {`PIF_IDX_FLAGS, 2'h0};
	localparam logic [11:0] AE = {`PIF_IDX_IEN, 2'h0};
	localparam logic [11:0] AG = {`PIF_IDX_EDGE, 2'h0};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] addr = 12'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [1:0] cmp = 2'h0;
	logic ser = 1'b0;
	logic urx = 1'b0;
	logic utx = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic slow = 1'b0;
	logic [3:0] be = 4'h1;
	logic [31:0] rdata;
	logic waitreq, ack, irq;
	logic [7:0] vec, entries, last_vec, q;
	logic [1:0] cen, coe, cref, csrc;
	int mismatches = 0;
	int comparisons = 0;

	always #50 clk = ~clk;

	pif_top u_pif_top (.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_CMP_OUT(cmp),
		.I_SERIAL_DONE(ser), .I_UART_RX_DONE(urx), .I_UART_TX_DONE(utx), .I_PIN_A(pa),
		.I_PIN_B(pb), .I_VECTOR_ACK(ack), .O_IRQ_REQ(irq), .O_VECTOR_ADDR(vec),
		.O_CMP_ENABLE(cen), .O_CMP_PIN_OUT_EN(coe), .O_CMP_REF_SEL(cref),
		.O_CMP_SOURCE_SEL(csrc));

	pif_core_model u_pif_core_model (.i_clk(clk), .i_arst_n(rst_n), .i_irq_req(irq),
		.i_vector_addr(vec), .i_slow(slow), .o_vector_ack(ack), .o_entries(entries),
		.o_last_vector(last_vec));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("counts: %0d compares, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic give_up(input string s);
		mismatches++;
		$display("BAD %0t %s", $time, s);
		close_out();
	endtask : give_up

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string s);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk8

	// ev raises the serial done input so that it lands on the write's own edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic ev);
		int n;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h000000, d};
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (waitreq === 1'b0)
				break;
			ser <= ev;
		end
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		ser <= 1'b0;
		if (n == 16)
			give_up("bus hang");
	endtask : bus

	task automatic wr8(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 1'b0);
	endtask : wr8

	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string s);
		bus(1'b0, a, 8'h00, 1'b0);
		chk8(q, e, s);
	endtask : rchk

	task automatic wait_entry(input logic [7:0] n0);
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (entries !== n0)
				break;
		end
		if (n == 20)
			give_up("no vector entry");
	endtask : wait_entry

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rchk(A0, 8'h00, "cmp0 reset");
		rchk(A1, 8'h00, "cmp1 reset");
		rchk(AF, 8'h00, "flags reset");
		rchk(AG, 8'h00, "edge reset");
		chk8(vec, `PIF_VECTOR_ADDR, "vector");
		be <= 4'h0;
		wr8(A0, 8'hFF);
		be <= 4'h1;
		rchk(A0, 8'h00, "write without lane");
		$display("test reset done");
	endtask : t_reset

	task automatic t_layout();
		wr8(A0, 8'hDF);
		wr8(A1, 8'hDF);
		rchk(A0, 8'hDB, "cmp0 layout");
		rchk(A1, 8'hD8, "cmp1 layout");
		chk8({cen, coe, cref, csrc}, 8'hFF, "cmp outputs");
		wr8(A0, 8'h20);
		wr8(A1, 8'h20);
		rchk(A0, 8'h20, "cmp0 flag write");
		rchk(A1, 8'h20, "cmp1 flag write");
		wr8(A0, 8'h00);
		wr8(A1, 8'h00);
		$display("test layout done");
	endtask : t_layout

	task automatic t_cmp_edge();
		wr8(A0, 8'h80);
		@(posedge clk);
		cmp <= 2'h3;
		rchk(A0, 8'hA4, "cmp0 rise");
		rchk(A1, 8'h04, "cmp1 disabled");
		wr8(A0, 8'h80);
		@(posedge clk);
		cmp <= 2'h0;
		rchk(A0, 8'h80, "cmp0 fall");
		wr8(A1, 8'h80);
		@(posedge clk);
		cmp <= 2'h2;
		rchk(A1, 8'hA4, "cmp1 rise");
		rchk(A0, 8'h80, "cmp0 untouched");
		wr8(A0, 8'h00);
		wr8(A1, 8'h00);
		$display("test comparator edges done");
	endtask : t_cmp_edge

	task automatic t_vector();
		logic [7:0] n0;
		n0 = entries;
		slow <= 1'b1;
		wr8(A0, 8'h40);
		wr8(A0, 8'h40);
		wr8(A0, 8'hC0);
		@(posedge clk);
		cmp <= 2'h1;
		repeat (4) @(posedge clk);
		chk8({7'h00, irq}, 8'h00, "irq without global");
		wr8(AE, 8'h80);
		wait_entry(n0);
		chk8(last_vec, `PIF_VECTOR_ADDR, "vector taken");
		rchk(AE, 8'h00, "global cleared");
		rchk(A0, 8'hE4, "poll cmp0");
		chk8({cen, coe, cref, csrc}, 8'h40, "cmp output order");
		wr8(A0, 8'h00);
		slow <= 1'b0;
		$display("test comparator vector done");
	endtask : t_vector

	task automatic t_done();
		int i;
		logic [7:0] n0;
		for (i = 0; i < 3; i++) begin
			wr8(AF, 8'h00);
			wr8(AE, 8'h80);
			n0 = entries;
			@(posedge clk);
			{utx, urx, ser} <= 3'h1 << i;
			@(posedge clk);
			{utx, urx, ser} <= 3'h0;
			rchk(AF, 8'h01 << i, "done flag");
			chk8(entries, n0, "no entry");
			wr8(AE, 8'h80 | (8'h01 << i));
			wait_entry(n0);
			rchk(AE, 8'h01 << i, "entry taken");
		end
		wr8(AE, 8'h00);
		$display("test done sources done");
	endtask : t_done

	task automatic t_edges();
		int i;
		logic [1:0] c;
		for (i = 0; i < 4; i++) begin
			c = i[1:0];
			wr8(AG, {3'h0, c, 3'h0});
			wr8(AF, 8'h00);
			@(posedge clk);
			{pa, pb} <= 2'h3;
			rchk(AF, {4'h0, c[0], 3'h0}, "pin rise");
			wr8(AF, 8'h00);
			@(posedge clk);
			{pa, pb} <= 2'h0;
			rchk(AF, {4'h1, c[1], 3'h0}, "pin fall");
		end
		bus(1'b1, AF, 8'h00, 1'b1);
		rchk(AF, 8'h01, "set over clear");
		$display("test pin edges done");
	endtask : t_edges

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_layout();
		t_cmp_edge();
		t_vector();
		t_done();
		t_edges();
		close_out();
	end
endmodule : pif_top_tb

`default_nettype wire
